// >>> sci_host.sv
`timescale 1ns/1ps
module sci_host (
   input wire logic i_sys_clk,   // system clock, host steps on its fall
   input wire logic i_sdo_wire,  // resolved serial out
   output logic o_sck,           // serial clock, idle low
   output logic o_select_strobe_n, // select strobe, idle high
   output logic o_sdi            // serial data
);
   initial begin
      o_sck = 1'b0;
      o_select_strobe_n = 1'b1;
      o_sdi = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask : wait_clk

   // half period of 4 clocks gives the 160 ns link clock
   task automatic xfer(input logic [15:0] w, input int rises, input logic park,
                       output logic [15:0] rd);
      rd = '0;
      wait_clk(1);
      if (park) begin
         o_sck = 1'b1;
         wait_clk(4);
      end
      o_select_strobe_n = 1'b0;
      for (int i = 0; i < rises; i++) begin
         o_sdi = (i < 16) ? w[15-i] : 1'b0;
         wait_clk(4);
         o_sck = 1'b1;
         if (i < 16) rd[15-i] = i_sdo_wire;
         wait_clk(4);
         o_sck = 1'b0;
      end
      wait_clk(4);
      if (rises == 0) rd[15] = i_sdo_wire;
      o_select_strobe_n = 1'b1;
      // no pull on the data line, so show the inverse once released
      o_sdi = ~o_sdi;
      wait_clk(4);
      o_sck = 1'b0;
      wait_clk(4);
   endtask : xfer

   // clock pulses with the strobe high, data wiggling as on a shared bus
   task automatic idle_pulses(input int n);
      for (int i = 0; i < n; i++) begin
         o_sdi = i[0];
         wait_clk(4);
         o_sck = 1'b1;
         wait_clk(4);
         o_sck = 1'b0;
      end
   endtask : idle_pulses
endmodule : sci_host

// >>> sci_pkg.sv
// What this block does
// RULE1: host sets data before each serial clock rise; device shifts one bit per rise.
// RULE2: strobe idles high; while high, clock edges are ignored entirely.
// RULE3: after 16 rises, strobe rise loads the register, applies it, clears diagnostics.
// RULE4: 1 to 15 or more than 16 rises cancels write, keeps diagnostics, sets error flags.
// RULE5: while strobe low, output shifts msb first, one bit per clock fall.
// RULE6: the summary fault flag appears on the output as soon as strobe falls.
// RULE7: frames are 16 bits msb first; eight writable registers exist.
// RULE8: word bits 15..13 select config 0..5, fault mask or run register.
// RULE9: bit 12 commits; data bits 11..0 are written only when it is one.
// RULE10: commit set returns diagnostics; clear returns the addressed register.
// RULE11: first three output bits are always summary, power-on and transfer error flags.
// RULE12: timing register holds recirc select, blank time and dead time.
// RULE13: voltage register holds decay, pwm invert, current ref, qualifier, drain threshold.
// RULE14: pwm register holds position gain, overspeed ratio, degauss, chop period.
// RULE15: hold register holds position integral gain, hold duty, hold duration.
// RULE16: start register holds velocity gain, startup duty, start frequency.
// RULE17: speed register holds velocity integral gain, output select, max speed, advance.
// RULE18: a set mask bit fully suppresses that fault's state, flag and bit.
// RULE19: run register holds mode, stop on fault, demand, restart, brake, direction, run.
// RULE20: restart allowed only with restart, run set and brake clear; coast only with restart clear.
// RULE21: reset loads register defaults; diagnostics come up with two top flags set.
// RULE22: summary fault flag is high whenever any other diagnostic bit is set.
// RULE23: clearing diagnostics keeps bits of faults that are still present.
// RULE24: a frame with no clock edges ends without error and releases the output.
// RULE25: serial output is high impedance whenever strobe is high.
// RULE26: clock, strobe and data pins are synchronised before edge detection.
package sci_pkg;

   localparam int SCI_WORD_BITS = 16;
   localparam int SCI_DATA_BITS = 12;
   localparam int SCI_NUM_REGS = 8;

   // frame layout
   localparam int SCI_ADDR_LSB = 13;
   localparam int SCI_COMMIT_BIT = 12;
   localparam logic [4:0] SCI_COMMIT_EDGE = 5'h04;
   localparam logic [4:0] SCI_FULL_EDGES = 5'h10;
   localparam logic [4:0] SCI_OVER_EDGES = 5'h11;
   localparam logic [3:0] SCI_LAST_FALL = 4'hf;

   // register addresses
   localparam logic [2:0] SCI_ADDR_TIMING = 3'h0;
   localparam logic [2:0] SCI_ADDR_VOLTAGE = 3'h1;
   localparam logic [2:0] SCI_ADDR_PWM = 3'h2;
   localparam logic [2:0] SCI_ADDR_HOLD = 3'h3;
   localparam logic [2:0] SCI_ADDR_START = 3'h4;
   localparam logic [2:0] SCI_ADDR_SPEED = 3'h5;
   localparam logic [2:0] SCI_ADDR_MASK = 3'h6;
   localparam logic [2:0] SCI_ADDR_RUN = 3'h7;

   // reset values, index = address
   localparam logic [SCI_NUM_REGS-1:0][SCI_DATA_BITS-1:0] SCI_REG_RST = {
      12'h009,  // run_control
      12'h000,  // fault_mask
      12'h778,  // speed_config
      12'h773,  // start_config
      12'h752,  // hold_config
      12'h793,  // pwm_config
      12'h3df,  // voltage_config
      12'h214   // timing_config
   };

   // fault_status layout
   localparam int SCI_DIAG_ANY = 15;
   localparam int SCI_DIAG_POR = 14;
   localparam int SCI_DIAG_XFER = 13;
   localparam logic [14:0] SCI_DIAG_RST = 15'h4000;
   // maskable fault positions: thermal, overtemp, sync, supply, six phase faults
   localparam logic [11:0] SCI_FAULT_VALID = 12'hebf;

   typedef struct packed {
      // run_control
      logic [1:0] control_mode_select;
      logic stop_on_fault;
      logic [4:0] serial_demand;
      logic restart_enable;
      logic brake_enable;
      logic direction;
      logic run_enable;
      // fault_mask
      logic [11:0] fault_mask;
      // speed_config
      logic [3:0] velocity_integral_gain;
      logic speed_output_select;
      logic [2:0] max_speed;
      logic [3:0] phase_advance;
      // start_config
      logic [3:0] velocity_prop_gain;
      logic [3:0] startup_duty;
      logic [3:0] start_freq;
      // hold_config
      logic [3:0] pos_integral_gain;
      logic [3:0] hold_duty;
      logic [3:0] hold_duration;
      // pwm_config
      logic [3:0] pos_prop_gain;
      logic [1:0] overspeed_ratio;
      logic degauss_comp;
      logic [4:0] chop_period;
      // voltage_config
      logic fast_decay_at_start;
      logic pwm_input_invert;
      logic [3:0] current_limit_ref;
      logic drain_monitor_qualifier;
      logic [4:0] drain_threshold;
      // timing_config
      logic [1:0] recirc_select;
      logic [3:0] blank_time;
      logic [5:0] dead_time;
   } sci_cfg_s;

endpackage : sci_pkg

// >>> sci_serial_config.sv
`timescale 1ns/1ps
module sci_serial_config
   import sci_pkg::*;
#(
   parameter int FRAME_BITS = 16
) (
   input wire logic i_sys_clk,              // 50 MHz system clock
   input wire logic i_rst_n,                // power-on reset, active low
   input wire logic i_sck,                  // serial clock pin
   input wire logic i_select_strobe_n,      // select strobe pin, active low
   input wire logic i_sdi,                  // serial data in pin
   output logic o_sdo,                      // serial data out
   output logic o_sdo_oe,                   // serial out drive enable
   input wire logic [11:0] i_fault_present, // raw fault conditions, diag bit order
   output logic [11:0] o_fault_state,       // unmasked fault states
   output sci_cfg_s o_cfg,                  // register contents
   output logic o_cfg_update,               // pulse: a register was written
   output logic o_restart_allowed,          // restart after sync loss permitted
   output logic o_coast_on_sync_loss,       // coast on sync loss
   output logic [15:0] o_fault_status       // diagnostic register
);

   initial begin
      if (FRAME_BITS != SCI_WORD_BITS) begin
         $error("sci_serial_config serves 16-bit frames only");
      end
   end

   // ----------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------
   logic [2:0] pins_s;
   logic sck_s;
   logic strb_s;
   logic sdi_s;

   sci_sync #(
      .WIDTH(3),
      .STAGES(2),
      .RST_VAL(3'h2)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_sck, i_select_strobe_n, i_sdi}),
      .o_sync(pins_s)
   ); // [RULE26]

   assign sck_s = pins_s[2];
   assign strb_s = pins_s[1];
   assign sdi_s = pins_s[0];

   // ----------------------------------------------------------
   // register state
   // ----------------------------------------------------------
   logic [SCI_NUM_REGS-1:0][SCI_DATA_BITS-1:0] regs_q;
   logic [SCI_NUM_REGS-1:0][SCI_DATA_BITS-1:0] regs_next;
   logic [14:0] diag_reg;
   logic [14:0] diag_next;
   logic update_reg;
   logic update_next;
   logic any_fault;
   logic [11:0] fault_act;

   // ----------------------------------------------------------
   // serial state
   // ----------------------------------------------------------
   logic sck_d_reg;
   logic sck_d_next;
   logic strb_d_reg;
   logic strb_d_next;
   logic [4:0] rise_cnt_reg;
   logic [4:0] rise_cnt_next;
   logic [3:0] fall_cnt_reg;
   logic [3:0] fall_cnt_next;
   logic [15:0] shift_in_reg;
   logic [15:0] shift_in_next;
   logic [15:0] out_word_reg;
   logic [15:0] out_word_next;
   logic sdo_reg;
   logic sdo_next;
   logic oe_reg;
   logic oe_next;

   logic sck_rise;
   logic sck_fall;
   logic frame_start;
   logic frame_end;
   logic frame_good;
   logic frame_bad;
   logic [3:0] next_fall;
   logic [2:0] rd_addr;

   // strobe high masks both clock edges, so shared lines stay quiet
   assign sck_rise = sck_s & ~sck_d_reg & ~strb_s;  // [RULE2]
   assign sck_fall = ~sck_s & sck_d_reg & ~strb_s;  // [RULE2]
   assign frame_start = ~strb_s & strb_d_reg;
   assign frame_end = strb_s & ~strb_d_reg;
   assign frame_good = frame_end && (rise_cnt_reg == SCI_FULL_EDGES);   // [RULE3]
   // zero edges is a legal poll and not an error
   assign frame_bad = frame_end && (rise_cnt_reg != SCI_FULL_EDGES)
                      && (rise_cnt_reg != 5'h00);                     // [RULE4] [RULE24]
   assign next_fall = fall_cnt_reg + 4'h1;
   assign rd_addr = shift_in_reg[2:0];

   assign any_fault = |diag_reg;  // [RULE22]

   always_comb begin
      sck_d_next = sck_s;
      strb_d_next = strb_s;
      rise_cnt_next = rise_cnt_reg;
      fall_cnt_next = fall_cnt_reg;
      shift_in_next = shift_in_reg;
      out_word_next = out_word_reg;
      sdo_next = sdo_reg;
      oe_next = oe_reg;
      if (frame_start) begin
         rise_cnt_next = 5'h00;
         fall_cnt_next = 4'h0;
         // flags first; the payload is chosen once the commit bit is in
         out_word_next = {any_fault, diag_reg[SCI_DIAG_POR], diag_reg[SCI_DIAG_XFER],
                          13'h0000};                            // [RULE11]
         sdo_next = any_fault;                                 // [RULE6]
         oe_next = 1'b1;
      end else if (strb_s) begin
         oe_next = 1'b0;                                       // [RULE25]
         sdo_next = 1'b0;
      end else begin
         if (sck_rise) begin
            shift_in_next = {shift_in_reg[14:0], sdi_s};       // [RULE1] [RULE7]
            if (rise_cnt_reg != SCI_OVER_EDGES) begin
               rise_cnt_next = rise_cnt_reg + 5'h01;
            end
            if (rise_cnt_reg == SCI_COMMIT_EDGE - 5'h01) begin
               if (sdi_s) begin
                  out_word_next[11:0] = diag_reg[11:0];        // [RULE10]
               end else begin
                  out_word_next[11:0] = regs_q[rd_addr];       // [RULE10] [RULE8]
               end
            end
         end
         if (sck_fall) begin
            if (fall_cnt_reg != SCI_LAST_FALL) begin
               fall_cnt_next = next_fall;
               sdo_next = out_word_reg[4'hf - next_fall];      // [RULE5]
            end else begin
               sdo_next = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sck_d_reg <= 1'b0;
         strb_d_reg <= 1'b1;
         rise_cnt_reg <= 5'h00;
         fall_cnt_reg <= 4'h0;
         shift_in_reg <= 16'h0000;
         out_word_reg <= 16'h0000;
         sdo_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         sck_d_reg <= sck_d_next;
         strb_d_reg <= strb_d_next;
         rise_cnt_reg <= rise_cnt_next;
         fall_cnt_reg <= fall_cnt_next;
         shift_in_reg <= shift_in_next;
         out_word_reg <= out_word_next;
         sdo_reg <= sdo_next;
         oe_reg <= oe_next;
      end
   end

   // ----------------------------------------------------------
   // registers and diagnostics
   // ----------------------------------------------------------
   // masked faults never reach any flag or state output
   assign fault_act = i_fault_present & ~regs_q[SCI_ADDR_MASK] & SCI_FAULT_VALID; // [RULE18]

   always_comb begin
      regs_next = regs_q;
      diag_next = diag_reg;
      update_next = 1'b0;
      if (frame_good) begin
         diag_next = 15'h0000;                                   // [RULE3]
         if (shift_in_reg[SCI_COMMIT_BIT]) begin
            regs_next[shift_in_reg[15:SCI_ADDR_LSB]] = shift_in_reg[11:0]; // [RULE8] [RULE9]
            update_next = 1'b1;
         end
      end
      if (frame_bad) begin
         diag_next[SCI_DIAG_XFER] = 1'b1;                        // [RULE4]
      end
      // set after clear: a fault still present survives the clear
      diag_next[11:0] = diag_next[11:0] | fault_act;             // [RULE23]
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         regs_q <= SCI_REG_RST;                                  // [RULE21]
         diag_reg <= SCI_DIAG_RST;                               // [RULE21]
         update_reg <= 1'b0;
      end else begin
         regs_q <= regs_next;
         diag_reg <= diag_next;
         update_reg <= update_next;
      end
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   assign o_sdo = sdo_reg;
   assign o_sdo_oe = oe_reg;
   assign o_fault_state = fault_act;
   // field placement follows the struct order
   assign o_cfg = sci_cfg_s'(regs_q);                  // [RULE12] [RULE13] [RULE14] [RULE15]
   assign o_cfg_update = update_reg;                   // [RULE16] [RULE17] [RULE19]
   assign o_restart_allowed = o_cfg.restart_enable & o_cfg.run_enable
                              & ~o_cfg.brake_enable;   // [RULE20]
   assign o_coast_on_sync_loss = ~o_cfg.restart_enable; // [RULE20]
   assign o_fault_status = {any_fault, diag_reg};

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   a_output_release: assert property ( // [RULE25]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      strb_s |=> !o_sdo_oe)
      else $error("serial output driven while strobe high");

   a_first_bit_flag: assert property ( // [RULE6]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      frame_start |=> (o_sdo_oe && o_sdo == $past(any_fault)))
      else $error("first output bit is not the summary flag");

   a_bad_frame_flags: assert property ( // [RULE4]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      frame_bad |=> (o_fault_status[SCI_DIAG_XFER] && o_fault_status[SCI_DIAG_ANY]))
      else $error("bad frame did not set error flags");

   a_bad_frame_nowrite: assert property ( // [RULE4]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      frame_bad |=> (regs_q == $past(regs_q) && !o_cfg_update))
      else $error("bad frame changed a register");

   a_good_frame_clear: assert property ( // [RULE3]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      frame_good |=> (!o_fault_status[SCI_DIAG_POR] && !o_fault_status[SCI_DIAG_XFER]))
      else $error("good frame did not clear diagnostics");

   a_commit_write: assert property ( // [RULE9]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (frame_good && shift_in_reg[SCI_COMMIT_BIT])
      |=> (regs_q[$past(shift_in_reg[15:13])] == $past(shift_in_reg[11:0]) && o_cfg_update))
      else $error("committed word not written");

   a_no_commit_hold: assert property ( // [RULE9]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (frame_good && !shift_in_reg[SCI_COMMIT_BIT]) |=> $stable(regs_q))
      else $error("uncommitted word changed a register");

   a_mask_blocks: assert property ( // [RULE18]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      ##1 ((diag_reg[11:0] & ~$past(diag_reg[11:0]) & $past(regs_q[SCI_ADDR_MASK])) == 12'h000))
      else $error("masked fault set a diagnostic bit");

   a_idle_no_count: assert property ( // [RULE2] [RULE24]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (frame_end && rise_cnt_reg == 5'h00)
      |=> (o_fault_status[SCI_DIAG_XFER] == $past(diag_reg[SCI_DIAG_XFER])) ##1 !o_sdo_oe)
      else $error("edgeless frame flagged an error or kept driving");

   a_present_kept: assert property ( // [RULE23]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (frame_good && fault_act != 12'h000) |=> ((diag_reg[11:0] & $past(fault_act)) ==
                                                 $past(fault_act)))
      else $error("present fault lost on clear");

   a_shift_sample: assert property ( // [RULE1]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      sck_rise |=> (shift_in_reg[0] == $past(sdi_s)))
      else $error("serial input bit not taken on clock rise");

   a_idle_shift_hold: assert property ( // [RULE2]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      strb_s |=> (rise_cnt_reg == $past(rise_cnt_reg) && shift_in_reg == $past(shift_in_reg)))
      else $error("clock edge counted while strobe high");

   a_frame_restart: assert property ( // [RULE3]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      frame_start |=> (rise_cnt_reg == 5'h00 && fall_cnt_reg == 4'h0))
      else $error("edge counters not cleared at frame start");

   a_rise_cap: assert property ( // [RULE4]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      rise_cnt_reg <= SCI_OVER_EDGES)
      else $error("rise counter ran past its cap");

   a_error_sticky: assert property ( // [RULE4]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (diag_reg[SCI_DIAG_XFER] && !frame_good) |=> diag_reg[SCI_DIAG_XFER])
      else $error("transfer error lost without a good frame");

   a_drive_in_frame: assert property ( // [RULE5]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!strb_s && !strb_d_reg) |-> o_sdo_oe)
      else $error("serial output not driven inside a frame");

   a_header_flags: assert property ( // [RULE11]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      frame_start |=> (out_word_reg[15:13] == {$past(any_fault),
                       $past(diag_reg[SCI_DIAG_POR]), $past(diag_reg[SCI_DIAG_XFER])}))
      else $error("output header is not the three flags");

   a_diag_payload: assert property ( // [RULE10]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (sck_rise && rise_cnt_reg == 5'h03 && sdi_s)
      |=> (out_word_reg[11:0] == $past(diag_reg[11:0])))
      else $error("commit frame does not return diagnostics");

   a_reg_payload: assert property ( // [RULE10] [RULE8]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (sck_rise && rise_cnt_reg == 5'h03 && !sdi_s)
      |=> (out_word_reg[11:0] == $past(regs_q[shift_in_reg[2:0]])))
      else $error("read frame does not return addressed register");

   a_quiet_low: assert property ( // [RULE25]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !o_sdo_oe |-> !o_sdo)
      else $error("serial output data high while released");

   a_regs_hold: assert property ( // [RULE9]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !frame_good |=> $stable(regs_q))
      else $error("register changed outside a good frame");

   // only reset may raise the power-on flag
   a_por_no_set: assert property ( // [RULE21]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !diag_reg[SCI_DIAG_POR] |=> !diag_reg[SCI_DIAG_POR])
      else $error("power-on flag set without reset");

endmodule : sci_serial_config

// >>> sci_serial_config_tb.sv
`timescale 1ns/1ps
module sci_serial_config_tb;
   import sci_pkg::*;
   logic i_sys_clk, i_rst_n, sck, strb_n, sdi, o_sdo, o_sdo_oe, o_cfg_update;
   logic o_restart_allowed, o_coast_on_sync_loss;
   logic [11:0] i_fault_present, o_fault_state;
   logic [15:0] o_fault_status, rd;
   sci_cfg_s o_cfg;
   logic [11:0] shadow [8];
   int miscompares, n_compared, updates;
   wire sdo_wire = o_sdo_oe ? o_sdo : 1'bz;

   sci_serial_config DUT (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sck(sck),
      .i_select_strobe_n(strb_n), .i_sdi(sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
      .i_fault_present(i_fault_present), .o_fault_state(o_fault_state),
      .o_cfg(o_cfg), .o_cfg_update(o_cfg_update),
      .o_restart_allowed(o_restart_allowed),
      .o_coast_on_sync_loss(o_coast_on_sync_loss), .o_fault_status(o_fault_status)
   );

   sci_host host (
      .i_sys_clk(i_sys_clk), .i_sdo_wire(sdo_wire), .o_sck(sck),
      .o_select_strobe_n(strb_n), .o_sdi(sdi)
   );

   initial begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end

   always @(posedge i_sys_clk) if (o_cfg_update === 1'b1) updates++;

   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [95:0] cfg_exp();
      logic [95:0] v;
      for (int a = 0; a < 8; a++) v[a*12 +: 12] = shadow[a];
      return v;
   endfunction : cfg_exp

   task automatic frame(input logic [15:0] w, input int n);
      host.xfer(w, n, 1'b0, rd);
   endtask : frame

   task automatic wr(input logic [2:0] a, input logic [11:0] v);
      frame({a, 1'b1, v}, 16);
      shadow[a] = v;
   endtask : wr

   // reads every register without commit; data bits must be ignored
   task automatic read_all(input logic [3:0] first_hdr);
      for (int a = 0; a < 8; a++) begin
         frame({a[2:0], 1'b0, 12'hfff}, 16);
         chk(rd, {(a == 0) ? first_hdr : 4'h0, shadow[a]});
      end
      chk(o_cfg, cfg_exp());
   endtask : read_all

   task automatic t_reset;
      for (int a = 0; a < 8; a++) shadow[a] = SCI_REG_RST[a];
      chk(o_fault_status, 16'hc000);
      chk(o_cfg, cfg_exp());
      chk(sdo_wire, 1'bz);
      read_all(4'hc);
      chk(o_fault_status, 16'h0000);
   endtask : t_reset

   task automatic t_write_all;
      updates = 0;
      for (int a = 0; a < 8; a++) begin
         if (a != 6) wr(a[2:0], 12'h3c5 ^ {4{a[2:0]}});
         else wr(a[2:0], 12'h000);
         chk(rd, 16'h0000);
      end
      chk(updates, 8);
      chk(o_cfg, cfg_exp());
      read_all(4'h0);
   endtask : t_write_all

   task automatic t_run_bits;
      logic [11:0] runs [4] = '{12'h00b, 12'h00d, 12'h001, 12'h008};
      logic [1:0] exp [4] = '{2'b10, 2'b00, 2'b01, 2'b00};
      for (int i = 0; i < 4; i++) begin
         wr(SCI_ADDR_RUN, runs[i]);
         chk({o_restart_allowed, o_coast_on_sync_loss}, exp[i]);
         chk(o_cfg.run_enable, runs[i][0]);
      end
   endtask : t_run_bits

   task automatic t_bad_counts;
      int cnt [3] = '{15, 17, 1};
      updates = 0;
      for (int i = 0; i < 3; i++) begin
         frame({SCI_ADDR_VOLTAGE, 1'b1, 12'h0ab}, cnt[i]);
         chk(o_cfg, cfg_exp());
         chk(o_fault_status, 16'ha000);
      end
      chk(updates, 0);
      host.xfer(16'h0000, 0, 1'b1, rd);
      chk(rd[15], 1'b1);
      chk(o_fault_status, 16'ha000);
      chk(sdo_wire, 1'bz);
      host.idle_pulses(20);
      chk(o_fault_status, 16'ha000);
      chk(o_cfg, cfg_exp());
      frame({SCI_ADDR_TIMING, 1'b0, 12'h000}, 16);
      chk(rd, {4'ha, shadow[0]});
      chk(o_fault_status, 16'h0000);
   endtask : t_bad_counts

   task automatic t_faults;
      @(negedge i_sys_clk) i_fault_present = 12'h880;
      repeat (3) @(negedge i_sys_clk);
      chk(o_fault_state, 12'h880);
      chk(o_fault_status, 16'h8880);
      wr(SCI_ADDR_RUN, shadow[7]);
      chk(rd, 16'h8880);
      chk(o_fault_status, 16'h8880);
      @(negedge i_sys_clk) i_fault_present = 12'h000;
      repeat (3) @(negedge i_sys_clk);
      chk(o_fault_status, 16'h8880);
      wr(SCI_ADDR_MASK, 12'h080);
      chk(o_fault_status, 16'h0000);
      @(negedge i_sys_clk) i_fault_present = 12'h880;
      repeat (3) @(negedge i_sys_clk);
      chk(o_fault_state, 12'h800);
      chk(o_fault_status, 16'h8800);
      @(negedge i_sys_clk) i_fault_present = 12'h000;
      wr(SCI_ADDR_MASK, 12'h000);
      chk(o_fault_status, 16'h0000);
   endtask : t_faults

   // power-on reset in mid-run must bring back every default over written values
   task automatic t_por_again;
      @(negedge i_sys_clk) i_rst_n = 1'b0;
      repeat (3) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      for (int a = 0; a < 8; a++) shadow[a] = SCI_REG_RST[a];
      chk(o_fault_status, 16'hc000);
      chk(o_cfg, cfg_exp());
      chk(sdo_wire, 1'bz);
      frame({SCI_ADDR_RUN, 1'b1, 12'h000}, 16);
      chk(rd, 16'hc000);
      chk(o_fault_status, 16'h0000);
   endtask : t_por_again

   task automatic conclude;
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   // whole run is well under 300 frames of about 3 us
   initial begin
      #1ms;
      miscompares++;
      conclude();
   end

   initial begin
      miscompares = 0;
      n_compared = 0;
      updates = 0;
      i_rst_n = 1'b0;
      i_fault_present = 12'h000;
      repeat (3) @(posedge i_sys_clk);
      @(negedge i_sys_clk) i_rst_n = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      t_reset();
      t_write_all();
      t_run_bits();
      t_bad_counts();
      t_faults();
      t_por_again();
      conclude();
   end
endmodule : sci_serial_config_tb

// >>> sci_sync.sv
`timescale 1ns/1ps
module sci_sync #(
   parameter int WIDTH = 3,
   parameter int STAGES = 2,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_sys_clk,          // system clock
   input wire logic i_rst_n,            // async reset, active low
   input wire logic [WIDTH-1:0] i_async, // pin levels
   output logic [WIDTH-1:0] o_sync      // synchronised levels
);

   initial begin
      if (STAGES < 2) begin
         $error("sci_sync needs at least two stages");
      end
   end

   logic [STAGES-1:0][WIDTH-1:0] stage_reg;

   // first stage feeds only the second stage
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage_reg <= {STAGES{RST_VAL}};
      end else begin
         stage_reg <= {stage_reg[STAGES-2:0], i_async};
      end
   end

   assign o_sync = stage_reg[STAGES-1];

endmodule : sci_sync
